// File: ahoc_calibrator.sv
// Purpose: Automatic calibration of the internal high-speed RC oscillator against USB start-of-frame
// Assumes: oscTick and sofPulse are one-cycle pulses already synchronous to clk_sys
// Notes: Oscillator must run slower than clk_sys so each of its cycles gives one tick
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Contract
// - Fine trim in bits 13:8, read-only
// - Fine trim step 20 kHz, default 32
// - Coarse value bits 7:0, read-only, default 128
// - Count at or below lower bound adjusts
// - Count at or above upper bound adjusts
// - Count inside window leaves trim alone; code still steps inside it while a search is running
// - Step back and forth across centre count
// - Keep setting whose count is closest
// - Unused upper bits read zero, ignore writes
// - Calibration-on starts searching for start-of-frame
// - Select bit picks coarse or fine value
// - Done flag with enable raises interrupt
module ahoc_calibrator
  import ahoc_pkg::*;
#(
  parameter int unsigned ADDR_W = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic oscTick,
  input wire logic sofPulse,
  output logic [5:0] fineTrim,
  output logic [7:0] coarseCal,
  output logic irq
);

  // Address must reach every register offset
  if (ADDR_W < MIN_ADDR_W || ADDR_W > 32) begin : gBadAddr
    $error("ADDR_W out of supported range");
  end

  // Register state
  logic calibration_on_r;
  logic fineSel_r;
  logic doneFlag_r;
  logic doneMask_r;
  logic [15:0] lower_r;
  logic [15:0] centre_r;
  logic [15:0] upper_r;
  logic [5:0] fine_r;
  logic [7:0] coarse_r;

  // Bus channel state
  logic awHeld_r;
  logic wHeld_r;
  logic [4:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [1:0] rResp_r;
  logic [31:0] rData_r;

  // Calibration state
  ahoc_state_t state_r;
  logic [15:0] oscCnt_r;
  logic adjusting_r;
  logic prevUp_r;
  logic [15:0] prevErr_r;
  logic [7:0] prevVal_r;

  // Write path: address and data may arrive in either order
  logic wrFire;
  logic [4:0] wrAddr;
  logic wrStatus;
  logic wrControl;
  logic wrLower;
  logic wrCentre;
  logic wrUpper;
  logic wrMask;
  logic wrMapped;

  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready = !wHeld_r && !bValid_r;
  assign wrFire = awHeld_r && wHeld_r && !bValid_r;
  assign wrAddr = {awAddr_r[4:2], 2'b00};
  assign wrStatus = wrFire && (wrAddr == OFS_STATUS);
  assign wrControl = wrFire && (wrAddr == OFS_CONTROL);
  assign wrLower = wrFire && (wrAddr == OFS_LOWER);
  assign wrCentre = wrFire && (wrAddr == OFS_CENTRE);
  assign wrUpper = wrFire && (wrAddr == OFS_UPPER);
  assign wrMask = wrFire && (wrAddr == OFS_MASK);
  // Trim readback is mapped but its writes are dropped
  assign wrMapped = wrStatus || wrControl || wrLower || wrCentre || wrUpper || wrMask || (wrAddr == OFS_TRIM);

  // Capture write address and data, respond once both are in
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 5'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[4:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // Read mux; reserved bits are forced low
  logic [31:0] rdWord;
  logic rdMapped;
  logic [4:0] rdAddr;
  assign rdAddr = {s_axi_araddr[4:2], 2'b00};

  always_comb begin
    rdWord = 32'h00000000;
    rdMapped = 1'b1;
    unique case (rdAddr)
      OFS_STATUS: rdWord[STS_DONE_BIT] = doneFlag_r;
      OFS_CONTROL: begin
        rdWord[CTL_ON_BIT] = calibration_on_r;
        rdWord[CTL_FINE_BIT] = fineSel_r;
      end
      OFS_TRIM: begin
        rdWord[TRIM_FINE_MSB:TRIM_FINE_LSB] = fine_r;
        rdWord[TRIM_COARSE_MSB:TRIM_COARSE_LSB] = coarse_r;
      end
      OFS_LOWER: rdWord[CMP_W-1:0] = lower_r;
      OFS_CENTRE: rdWord[CMP_W-1:0] = centre_r;
      OFS_UPPER: rdWord[CMP_W-1:0] = upper_r;
      OFS_MASK: rdWord[STS_DONE_BIT] = doneMask_r;
      default: rdMapped = 1'b0;
    endcase
  end

  // Read channel answers one cycle after the address is taken
  assign s_axi_arready = !rValid_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rValid_r <= 1'b0;
      rResp_r <= RESP_OKAY;
      rData_r <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      rData_r <= rdWord;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_r;
  assign s_axi_rresp = rResp_r;
  assign s_axi_rdata = rData_r;

  // Control and mask bits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      calibration_on_r <= 1'b0;
      fineSel_r <= 1'b0;
      doneMask_r <= 1'b0;
    end else begin
      if (wrControl && wStrb_r[0]) begin
        calibration_on_r <= wData_r[CTL_ON_BIT];
        fineSel_r <= wData_r[CTL_FINE_BIT];
      end
      if (wrMask && wStrb_r[0]) begin
        doneMask_r <= wData_r[STS_DONE_BIT];
      end
    end
  end

  // Compare registers, byte lanes honoured, upper lanes dropped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lower_r <= LOWER_RST;
      centre_r <= CENTRE_RST;
      upper_r <= UPPER_RST;
    end else begin
      if (wrLower && wStrb_r[0]) lower_r[7:0] <= wData_r[7:0];
      if (wrLower && wStrb_r[1]) lower_r[15:8] <= wData_r[15:8];
      if (wrCentre && wStrb_r[0]) centre_r[7:0] <= wData_r[7:0];
      if (wrCentre && wStrb_r[1]) centre_r[15:8] <= wData_r[15:8];
      if (wrUpper && wStrb_r[0]) upper_r[7:0] <= wData_r[7:0];
      if (wrUpper && wStrb_r[1]) upper_r[15:8] <= wData_r[15:8];
    end
  end

  // Sequencer: idle, hunt for the first frame mark, then measure frame by frame
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: if (calibration_on_r) state_r <= ST_SEARCH;
        ST_SEARCH: begin
          if (!calibration_on_r) state_r <= ST_IDLE;
          else if (sofPulse) state_r <= ST_MEASURE;
        end
        ST_MEASURE: if (!calibration_on_r) state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Oscillator cycles between frame marks; saturates so a lost frame cannot wrap
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oscCnt_r <= 16'h0000;
    end else if (state_r == ST_IDLE || sofPulse) begin
      oscCnt_r <= 16'h0000;
    end else if (oscTick && oscCnt_r != CNT_MAX) begin
      oscCnt_r <= oscCnt_r + 16'h0001;
    end
  end

  // Evaluation of one frame's sample
  logic sampleEvt;
  logic outOfWindow;
  logic needUp;
  logic [15:0] errNow;
  logic [7:0] activeVal;
  logic [7:0] activeMax;
  logic [7:0] steppedVal;
  logic [7:0] bestVal;
  logic [7:0] newVal;
  logic crossed;
  logic applyStep;
  logic applyBest;
  logic limitHit;
  logic writeVal;

  assign sampleEvt = (state_r == ST_MEASURE) && calibration_on_r && sofPulse;
  assign outOfWindow = (oscCnt_r <= lower_r) || (oscCnt_r >= upper_r);
  assign needUp = oscCnt_r < centre_r;
  assign errNow = needUp ? (centre_r - oscCnt_r) : (oscCnt_r - centre_r);
  assign activeVal = fineSel_r ? {2'b00, fine_r} : coarse_r;
  assign activeMax = fineSel_r ? FINE_MAX : COARSE_MAX;
  // A slow oscillator is sped up one step, a fast one slowed one step
  assign steppedVal = needUp ? ((activeVal == activeMax) ? activeVal : activeVal + 8'h01)
                             : ((activeVal == TRIM_MIN) ? activeVal : activeVal - 8'h01);
  assign crossed = adjusting_r && (needUp != prevUp_r);
  // Ties keep the newer setting; either way the error is within half a step
  assign bestVal = (errNow <= prevErr_r) ? activeVal : prevVal_r;
  assign applyBest = sampleEvt && crossed;
  assign applyStep = sampleEvt && !crossed && (adjusting_r || outOfWindow);
  assign limitHit = applyStep && (steppedVal == activeVal);
  assign newVal = applyBest ? bestVal : steppedVal;
  assign writeVal = applyBest || applyStep;

  // Search bookkeeping: remember the last setting and which side it landed on
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      adjusting_r <= 1'b0;
      prevUp_r <= 1'b0;
      prevErr_r <= 16'h0000;
      prevVal_r <= 8'h00;
    end else if (state_r != ST_MEASURE) begin
      adjusting_r <= 1'b0;
    end else if (applyBest || limitHit) begin
      adjusting_r <= 1'b0;
    end else if (applyStep) begin
      adjusting_r <= 1'b1;
      prevUp_r <= needUp;
      prevErr_r <= errNow;
      prevVal_r <= activeVal;
    end
  end

  // Trim values are steered only by the calibrator, never by the bus
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fine_r <= FINE_RST;
      coarse_r <= COARSE_RST;
    end else if (writeVal) begin
      if (fineSel_r) fine_r <= newVal[FINE_W-1:0];
      else coarse_r <= newVal;
    end
  end

  // Done flag: set on convergence or at a trim limit; a set beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      doneFlag_r <= 1'b0;
    end else if (applyBest || limitHit) begin
      doneFlag_r <= 1'b1;
    end else if (wrStatus && wStrb_r[0] && wData_r[STS_DONE_BIT]) begin
      doneFlag_r <= 1'b0;
    end
  end

  // Level interrupt while the unmasked flag stands
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= doneFlag_r && doneMask_r;
    end
  end

  // Trim values drive the oscillator directly
  assign fineTrim = fine_r;
  assign coarseCal = coarse_r;

endmodule

// File: ahoc_pkg.sv
// Purpose: Shared constants and types for the high-speed oscillator auto calibrator
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes: Offsets are byte addresses on the register bus
package ahoc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_CONTROL = 5'h04;
  localparam logic [4:0] OFS_TRIM = 5'h08;
  localparam logic [4:0] OFS_LOWER = 5'h0C;
  localparam logic [4:0] OFS_CENTRE = 5'h10;
  localparam logic [4:0] OFS_UPPER = 5'h14;
  localparam logic [4:0] OFS_MASK = 5'h18;
  localparam int unsigned MIN_ADDR_W = 5;

  // Field positions
  localparam int unsigned STS_DONE_BIT = 0;
  localparam int unsigned CTL_ON_BIT = 0;
  localparam int unsigned CTL_FINE_BIT = 1;
  localparam int unsigned TRIM_FINE_LSB = 8;
  localparam int unsigned TRIM_FINE_MSB = 13;
  localparam int unsigned TRIM_COARSE_LSB = 0;
  localparam int unsigned TRIM_COARSE_MSB = 7;
  localparam int unsigned FINE_W = 6;
  localparam int unsigned COARSE_W = 8;
  localparam int unsigned CMP_W = 16;

  // Reset values
  localparam logic [15:0] LOWER_RST = 16'h1F2C;
  localparam logic [15:0] CENTRE_RST = 16'h1F40;
  localparam logic [15:0] UPPER_RST = 16'h1F54;
  localparam logic [5:0] FINE_RST = 6'h20;
  localparam logic [7:0] COARSE_RST = 8'h80;

  // Trim limits, expressed in the 8-bit working width, and the 16-bit count ceiling
  localparam logic [7:0] FINE_MAX = 8'h3F;
  localparam logic [7:0] COARSE_MAX = 8'hFF;
  localparam logic [7:0] TRIM_MIN = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEARCH = 2'b01,
    ST_MEASURE = 2'b10
  } ahoc_state_t;

endpackage

// File: ahoc_asserts.sv
// Purpose: Port-level checks for the oscillator auto calibrator
// Assumes: One clock domain, reset_n active low
// Notes: Trim and interrupt checks only; bus checks kept to read data
`timescale 1ns/1ps
module ahoc_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic sofPulse,
  input wire logic [5:0] fineTrim,
  input wire logic [7:0] coarseCal,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Trims may only move at a frame boundary
  property p_fine_sof; $changed(fineTrim) |-> $past(sofPulse); endproperty
  a_fine_sof: assert property (p_fine_sof) else $error("fine trim moved off frame");
  property p_coarse_sof; $changed(coarseCal) |-> $past(sofPulse); endproperty
  a_coarse_sof: assert property (p_coarse_sof) else $error("coarse moved off frame");
  // One step at a time, also when falling back to the previous setting
  property p_fine_step;
    $changed(fineTrim) |-> fineTrim == $past(fineTrim) + 6'h01 || fineTrim == $past(fineTrim) - 6'h01;
  endproperty
  a_fine_step: assert property (p_fine_step) else $error("fine trim jumped");
  property p_coarse_step;
    $changed(coarseCal) |-> coarseCal == $past(coarseCal) + 8'h01 || coarseCal == $past(coarseCal) - 8'h01;
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("coarse jumped");
  property p_one_trim; !($changed(fineTrim) && $changed(coarseCal)); endproperty
  a_one_trim: assert property (p_one_trim) else $error("both trims moved");
  // Interrupt follows a frame result or a register write
  property p_irq_rise; $rose(irq) |-> $past(sofPulse, 2) || $past(s_axi_bvalid); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall; $fell(irq) |-> $past(s_axi_bvalid); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  // Every register is at most 16 bits wide
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  c_fine: cover property ($changed(fineTrim));
  c_coarse: cover property ($changed(coarseCal));
  c_irq: cover property ($rose(irq));
endmodule

bind ahoc_calibrator ahoc_asserts i_chk (.clk_sys, .reset_n, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .sofPulse, .fineTrim, .coarseCal, .irq);

// File: ahoc_sof_model.sv
// Purpose: Frame source plus behavioural oscillator seen through its tick count
// Assumes: Count per frame is fine + 2 * coarse, far shorter than a real frame
// Notes: Trim is read a few cycles after each frame mark so new values apply next frame
`timescale 1ns/1ps
module ahoc_sof_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [5:0] fineTrim,
  input wire logic [7:0] coarseCal,
  output logic oscTick,
  output logic sofPulse
);
  logic [1:0] gap_r;
  logic [16:0] left_r;
  logic [15:0] count;

  // Coarse step is twice the fine step
  assign count = {10'h000, fineTrim} + {7'h00, coarseCal, 1'h0};

  // Ticks every other cycle, then one frame mark on a cycle of its own
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gap_r <= 2'h0;
      left_r <= 17'h00000;
      oscTick <= 1'h0;
      sofPulse <= 1'h0;
    end else begin
      sofPulse <= 1'h0;
      oscTick <= 1'h0;
      if (gap_r != 2'h0) begin
        gap_r <= gap_r - 2'h1;
        if (gap_r == 2'h1) left_r <= {count, 1'h0};
      end else if (left_r != 17'h00000) begin
        left_r <= left_r - 17'h00001;
        oscTick <= left_r[0];
      end else begin
        sofPulse <= 1'h1;
        gap_r <= 2'h3;
      end
    end
  end
endmodule

// File: auto_hs_osc_calibrator_tb_top.sv
// Purpose: Self-checking bench for the oscillator auto calibrator
// Assumes: Compare values are shrunk so each frame lasts some 600 cycles
// Notes: Expected trims follow from the model count fine + 2 * coarse
`timescale 1ns/1ps
module auto_hs_osc_calibrator_tb_top;
  import ahoc_pkg::*;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, oscTick, sofPulse, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [5:0] fineTrim;
  logic [7:0] coarseCal;
  int n_mismatch = 0;
  int comparisons = 0;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  ahoc_calibrator i_dut (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .oscTick,
    .sofPulse, .fineTrim, .coarseCal, .irq);
  ahoc_sof_model i_usb (.clk_sys, .reset_n, .fineTrim, .coarseCal, .oscTick, .sofPulse);

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Each channel is released at the edge that takes it
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] eb = RESP_OKAY);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, eb});
    s_axi_bready <= 1'h0;
  endtask

  // A nonzero lag holds rready low for a while so the slave must keep its answer standing
  task rd(input logic [4:0] a, input int lag = 0);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= (lag == 0);
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (lag == 1) s_axi_rready <= 1'h1;
      if (lag > 0) lag--;
    end while (s_axi_rvalid !== 1'h1 || s_axi_rready !== 1'h1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task rchk(input string nm, input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY,
            input int lag = 0);
    rd(a, lag);
    chk(nm, rv, exp);
    chk("rresp", {30'h0, rs}, {30'h0, er});
  endtask

  // Poll the done flag once per frame, bounded to twenty frames
  task waitDone;
    rv = 32'h0;
    for (int i = 0; i < 20 && rv[0] !== 1'h1; i++) begin
      @(posedge sofPulse);
      rd(OFS_STATUS);
    end
  endtask

  task frames(input int n);
    repeat (n) @(posedge sofPulse);
    repeat (4) @(posedge clk_sys);
  endtask

  task irqChk(input logic [31:0] exp);
    repeat (2) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, exp);
  endtask

  task t_regs;
    rchk("trim", OFS_TRIM, 32'h00002080);
    rchk("lower", OFS_LOWER, 32'h00001F2C);
    rchk("centre", OFS_CENTRE, 32'h00001F40, RESP_OKAY, 2);
    rchk("upper", OFS_UPPER, 32'h00001F54);
    wr(OFS_LOWER, 32'hFFFFFFFF);
    rchk("lower", OFS_LOWER, 32'h0000FFFF);
    wr(OFS_TRIM, 32'hFFFFFFFF);
    rchk("trim", OFS_TRIM, 32'h00002080);
    rchk("unmapped", 5'h1C, 32'h0, RESP_SLVERR);
    wr(5'h1C, 32'hFFFFFFFF, RESP_SLVERR);
    rchk("upper", OFS_UPPER, 32'h00001F54);
    frames(3);
    chk("fine", {26'h0, fineTrim}, 32'h20);
    $display("test regs done");
  endtask

  // Count 288 starts below the window and climbs to the centre 294
  task t_fine;
    wr(OFS_CENTRE, 32'h126);
    wr(OFS_LOWER, 32'h122);
    wr(OFS_UPPER, 32'h12A);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CONTROL, 32'h3);
    waitDone;
    chk("fine", {26'h0, fineTrim}, 32'h26);
    chk("coarse", {24'h0, coarseCal}, 32'h80);
    irqChk(32'h1);
    frames(3);
    chk("fine", {26'h0, fineTrim}, 32'h26);
    wr(OFS_STATUS, 32'h1);
    irqChk(32'h0);
    $display("test fine done");
  endtask

  // Count 294 starts above; stepping down overshoots, so the previous setting wins
  task t_coarse;
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_LOWER, 32'h100);
    wr(OFS_CENTRE, 32'h11E);
    wr(OFS_UPPER, 32'h120);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CONTROL, 32'h1);
    waitDone;
    rchk("trim", OFS_TRIM, 32'h0000267C);
    irqChk(32'h0);
    wr(OFS_MASK, 32'h1);
    irqChk(32'h1);
    wr(OFS_STATUS, 32'h1);
    irqChk(32'h0);
    $display("test coarse done");
  endtask

  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // About 12000 cycles expected; the watchdog allows 50000
  initial begin
    #400000;
    n_mismatch++;
    $display("watchdog expired");
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_regs;
    t_fine;
    t_coarse;
    stop_test;
  end
endmodule
